/* File: hdl/fcap_pkg.sv */
// Purpose: Constants for the fault address capture block
// Assumes: 32-bit system control space register port, byte offsets
// Notes: Operation list below, one line per behaviour
// Operation
// RULE_01 - Escalation and vector flags clear on one
// RULE_02 - Vector fetch bus error sets vector flag
// RULE_03 - Memory fault captures offending address, flagged valid
// RULE_04 - Unaligned memory fault keeps actual faulting address
// RULE_05 - Split access address may be any span byte
// RULE_06 - Bus fault captures offending address, flagged valid
// RULE_07 - Unaligned bus fault keeps requested address
// RULE_08 - Unprivileged access to these registers is rejected
// RULE_09 - Memory fault address register writable, no reset
// RULE_10 - Separate status bits qualify each address register
// RULE_11 - Escalation to hard fault sets escalation flag
// RULE_12 - Vector bus error always goes to hard fault
package fcap_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam logic [ADDR_W-1:0] OFS_HARD_STAT = 12'hD2C;
   localparam logic [ADDR_W-1:0] OFS_VALID_STAT = 12'hD28;
   localparam logic [ADDR_W-1:0] OFS_MM_ADDR = 12'hD34;
   localparam logic [ADDR_W-1:0] OFS_BUS_ADDR = 12'hD38;
   localparam logic [ADDR_W-1:0] OFS_PROT_LO = 12'hD90;
   localparam logic [ADDR_W-1:0] OFS_PROT_HI = 12'hDEC;
   localparam int BIT_ESCALATED = 30;
   localparam int BIT_VECT_ERR = 1;
   localparam int BIT_MM_VALID = 0;
   localparam int BIT_BUS_VALID = 1;
   localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;
   localparam logic [1:0] SYNC_RST = 2'h0;
endpackage : fcap_pkg

/* File: hdl/fcap_top.sv */
// Purpose: Hard fault flags and fault address capture registers
// Assumes: Core fault events are one-cycle pulses on CLK
// Notes: Register answers come one cycle after REG_SEL
// Notes: Capture registers hold no reset value
`timescale 1ns/100ps
module fcap_top (
   input wire logic CLK,
   input wire logic ARST_N,
   input wire logic REG_SEL,
   input wire logic REG_WR,
   input wire logic [fcap_pkg::ADDR_W-1:0] REG_ADDR,
   input wire logic [fcap_pkg::DATA_W-1:0] REG_WDATA,
   input wire logic REG_PRIV,
   output logic [fcap_pkg::DATA_W-1:0] REG_RDATA,
   output logic REG_ACK,
   output logic REG_ERR,
   input wire logic MM_FAULT,
   input wire logic BUS_FAULT,
   input wire logic [fcap_pkg::DATA_W-1:0] ACC_REQ_ADDR,
   input wire logic [fcap_pkg::DATA_W-1:0] ACC_BEAT_ADDR,
   input wire logic VECT_BUS_ERR,
   input wire logic ESCALATE,
   input wire logic BUS_FAULT_EN,
   output logic HARD_FAULT_REQ,
   output logic BUS_FAULT_REQ
);
   import fcap_pkg::*;

   // Reset release through two flops
   logic [1:0] rst_sync_ff;
   logic [1:0] nxt_rst_sync;
   logic rst_n;

   always_comb begin
      nxt_rst_sync = {rst_sync_ff[0], 1'b1};
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         rst_sync_ff <= SYNC_RST;
      end else begin
         rst_sync_ff <= nxt_rst_sync;
      end
   end
   assign rst_n = rst_sync_ff[1];

   // Register access decode
   logic hit_hard;
   logic hit_valid;
   logic hit_mm;
   logic hit_bus;
   logic hit_prot;
   logic hit_any;
   logic acc_ok;
   logic wr_ok;

   always_comb begin
      hit_hard = 1'b0;
      hit_valid = 1'b0;
      hit_mm = 1'b0;
      hit_bus = 1'b0;
      hit_prot = 1'b0;
      if (REG_ADDR == OFS_HARD_STAT) begin
         hit_hard = 1'b1;
      end else if (REG_ADDR == OFS_VALID_STAT) begin
         hit_valid = 1'b1;
      end else if (REG_ADDR == OFS_MM_ADDR) begin
         hit_mm = 1'b1;
      end else if (REG_ADDR == OFS_BUS_ADDR) begin
         hit_bus = 1'b1;
      end else if (REG_ADDR >= OFS_PROT_LO && REG_ADDR <= OFS_PROT_HI) begin
         hit_prot = 1'b1;
      end
   end

   assign hit_any = hit_hard | hit_valid | hit_mm | hit_bus | hit_prot;
   assign acc_ok = REG_SEL & REG_PRIV; // RULE_08
   assign wr_ok = acc_ok & REG_WR;

   // Accepted read and refused access
   logic rd_ok;
   logic refuse;

   assign rd_ok = acc_ok & ~REG_WR;
   assign refuse = REG_SEL & ~REG_PRIV & hit_any; // RULE_08

   // Write-one-to-clear strobes, address register write strobes and core event strobes
   logic clr_escalated;
   logic clr_vect_err;
   logic clr_mm_valid;
   logic clr_bus_valid;
   logic wr_mm;
   logic wr_bus;
   logic set_escalated;
   logic set_vect_err;
   logic set_mm_valid;
   logic set_bus_valid;

   always_comb begin
      clr_escalated = wr_ok & hit_hard & REG_WDATA[BIT_ESCALATED]; // RULE_01
      clr_vect_err = wr_ok & hit_hard & REG_WDATA[BIT_VECT_ERR]; // RULE_01
      clr_mm_valid = wr_ok & hit_valid & REG_WDATA[BIT_MM_VALID]; // RULE_10
      clr_bus_valid = wr_ok & hit_valid & REG_WDATA[BIT_BUS_VALID]; // RULE_10
      wr_mm = wr_ok & hit_mm; // RULE_09
      wr_bus = wr_ok & hit_bus;
      set_escalated = ESCALATE; // RULE_11
      set_vect_err = VECT_BUS_ERR; // RULE_02
      set_mm_valid = MM_FAULT; // RULE_03
      set_bus_valid = BUS_FAULT; // RULE_06
   end

   // Hard fault status flags
   logic escalated_ff;
   logic vect_err_ff;
   logic nxt_escalated;
   logic nxt_vect_err;

   always_comb begin
      nxt_escalated = escalated_ff;
      nxt_vect_err = vect_err_ff;
      if (clr_escalated) begin
         nxt_escalated = 1'b0; // RULE_01
      end
      if (clr_vect_err) begin
         nxt_vect_err = 1'b0; // RULE_01
      end
      // Set wins over a clear in the same cycle
      if (set_escalated) begin
         nxt_escalated = 1'b1; // RULE_11
      end
      if (set_vect_err) begin
         nxt_vect_err = 1'b1; // RULE_02
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         escalated_ff <= 1'b0;
         vect_err_ff <= 1'b0;
      end else begin
         escalated_ff <= nxt_escalated;
         vect_err_ff <= nxt_vect_err;
      end
   end

   // Address valid flags, one per capture register
   logic mm_valid_ff;
   logic bus_valid_ff;
   logic nxt_mm_valid;
   logic nxt_bus_valid;

   always_comb begin
      nxt_mm_valid = mm_valid_ff;
      nxt_bus_valid = bus_valid_ff;
      if (clr_mm_valid) begin
         nxt_mm_valid = 1'b0; // RULE_10
      end
      if (clr_bus_valid) begin
         nxt_bus_valid = 1'b0; // RULE_10
      end
      // Set wins over a clear in the same cycle
      if (set_mm_valid) begin
         nxt_mm_valid = 1'b1; // RULE_03
      end
      if (set_bus_valid) begin
         nxt_bus_valid = 1'b1; // RULE_06
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         mm_valid_ff <= 1'b0;
         bus_valid_ff <= 1'b0;
      end else begin
         mm_valid_ff <= nxt_mm_valid;
         bus_valid_ff <= nxt_bus_valid;
      end
   end

   // Capture enables; a clear in the same cycle frees the register
   logic cap_mm;
   logic cap_bus;

   assign cap_mm = set_mm_valid & (~mm_valid_ff | clr_mm_valid); // RULE_03
   assign cap_bus = set_bus_valid & (~bus_valid_ff | clr_bus_valid); // RULE_06

   // Address capture registers, no reset value
   logic [DATA_W-1:0] mm_addr_ff;
   logic [DATA_W-1:0] bus_addr_ff;
   logic [DATA_W-1:0] nxt_mm_addr;
   logic [DATA_W-1:0] nxt_bus_addr;

   always_comb begin
      nxt_mm_addr = mm_addr_ff;
      nxt_bus_addr = bus_addr_ff;
      if (wr_mm) begin
         nxt_mm_addr = REG_WDATA; // RULE_09
      end
      if (wr_bus) begin
         nxt_bus_addr = REG_WDATA;
      end
      // Fault capture wins over a software write
      if (cap_mm) begin
         // Beat address of the failing access, any byte of the span
         nxt_mm_addr = ACC_BEAT_ADDR; // RULE_03 RULE_04 RULE_05
      end
      if (cap_bus) begin
         nxt_bus_addr = ACC_REQ_ADDR; // RULE_06 RULE_07
      end
   end

   always_ff @(posedge CLK) begin
      mm_addr_ff <= nxt_mm_addr; // RULE_09
      bus_addr_ff <= nxt_bus_addr;
   end

   // Fault routing toward the exception logic
   logic hard_req_ff;
   logic bus_req_ff;
   logic nxt_hard_req;
   logic nxt_bus_req;

   logic route_hard;
   logic route_bus;

   assign route_hard = set_vect_err | set_escalated; // RULE_12
   assign route_bus = set_bus_valid & BUS_FAULT_EN & ~set_vect_err; // RULE_12

   always_comb begin
      nxt_hard_req = route_hard; // RULE_12
      nxt_bus_req = route_bus; // RULE_12
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         hard_req_ff <= 1'b0;
         bus_req_ff <= 1'b0;
      end else begin
         hard_req_ff <= nxt_hard_req;
         bus_req_ff <= nxt_bus_req;
      end
   end

   assign HARD_FAULT_REQ = hard_req_ff;
   assign BUS_FAULT_REQ = bus_req_ff;

   // Status words as software sees them
   logic [DATA_W-1:0] hard_word;
   logic [DATA_W-1:0] valid_word;

   always_comb begin
      hard_word = ZERO_WORD;
      valid_word = ZERO_WORD;
      hard_word[BIT_ESCALATED] = escalated_ff; // RULE_11
      hard_word[BIT_VECT_ERR] = vect_err_ff; // RULE_02
      valid_word[BIT_MM_VALID] = mm_valid_ff; // RULE_10
      valid_word[BIT_BUS_VALID] = bus_valid_ff; // RULE_10
   end

   // Read data and answer
   logic [DATA_W-1:0] rdata_ff;
   logic ack_ff;
   logic err_ff;
   logic [DATA_W-1:0] nxt_rdata;
   logic nxt_ack;
   logic nxt_err;

   always_comb begin
      nxt_rdata = ZERO_WORD;
      nxt_ack = REG_SEL;
      nxt_err = refuse; // RULE_08
      if (rd_ok) begin
         if (hit_hard) begin
            nxt_rdata = hard_word;
         end else if (hit_valid) begin
            nxt_rdata = valid_word;
         end else if (hit_mm) begin
            nxt_rdata = mm_addr_ff;
         end else if (hit_bus) begin
            nxt_rdata = bus_addr_ff;
         end else begin
            // Protection unit and unmapped offsets read as zero
            nxt_rdata = ZERO_WORD;
         end
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         rdata_ff <= ZERO_WORD;
         ack_ff <= 1'b0;
         err_ff <= 1'b0;
      end else begin
         rdata_ff <= nxt_rdata;
         ack_ff <= nxt_ack;
         err_ff <= nxt_err;
      end
   end

   assign REG_RDATA = rdata_ff;
   assign REG_ACK = ack_ff;
   assign REG_ERR = err_ff;

endmodule // fcap_top

/* File: verif/fcap_props.sv */
// Purpose: Port checks for fcap_top
// Assumes: No request before the third edge after reset release
// Notes: Bound to every fcap_top
`timescale 1ns/100ps
module fcap_props (
   input wire logic CLK,
   input wire logic ARST_N,
   input wire logic REG_SEL,
   input wire logic REG_PRIV,
   input wire logic [fcap_pkg::ADDR_W-1:0] REG_ADDR,
   input wire logic [fcap_pkg::DATA_W-1:0] REG_RDATA,
   input wire logic REG_ACK,
   input wire logic REG_ERR,
   input wire logic BUS_FAULT,
   input wire logic VECT_BUS_ERR,
   input wire logic ESCALATE,
   input wire logic BUS_FAULT_EN,
   input wire logic HARD_FAULT_REQ,
   input wire logic BUS_FAULT_REQ
);
   import fcap_pkg::*;
   default clocking @(posedge CLK); endclocking
   default disable iff (!ARST_N);
   a_ack_pulse: assert property (REG_SEL |=> REG_ACK)
      else $error("ack missing");
   a_unpriv_err: assert property (REG_SEL && !REG_PRIV && REG_ADDR == OFS_MM_ADDR |=>
      REG_ERR && REG_RDATA == ZERO_WORD) else $error("unprivileged access not refused");
   a_priv_ok: assert property (REG_SEL && REG_PRIV |=> !REG_ERR)
      else $error("privileged access refused");
   a_rd_idle: assert property ($fell(REG_ACK) |-> REG_RDATA == ZERO_WORD)
      else $error("read data not cleared");
   a_hard_req: assert property (VECT_BUS_ERR || ESCALATE |=> HARD_FAULT_REQ)
      else $error("hard fault request missing");
   a_hard_quiet: assert property (!VECT_BUS_ERR && !ESCALATE |=> !HARD_FAULT_REQ)
      else $error("spurious hard fault request");
   a_vect_only_hard: assert property (VECT_BUS_ERR |=> !BUS_FAULT_REQ)
      else $error("vector error sent to bus handler");
   a_bus_req: assert property (BUS_FAULT && BUS_FAULT_EN && !VECT_BUS_ERR |=> BUS_FAULT_REQ)
      else $error("bus fault request missing");
endmodule // fcap_props
bind fcap_top fcap_props i_props (.CLK, .ARST_N, .REG_SEL, .REG_PRIV, .REG_ADDR, .REG_RDATA,
   .REG_ACK, .REG_ERR, .BUS_FAULT, .VECT_BUS_ERR, .ESCALATE, .BUS_FAULT_EN,
   .HARD_FAULT_REQ, .BUS_FAULT_REQ);

/* File: verif/fcap_core.sv */
// Purpose: Core side fault event source
// Assumes: Events change on falling CLK edges
// Notes: Address lines invert when not valid
`timescale 1ns/100ps
module fcap_core (
   input wire logic CLK,
   output logic MM_FAULT,
   output logic BUS_FAULT,
   output logic VECT_BUS_ERR,
   output logic ESCALATE,
   output logic [31:0] ACC_REQ_ADDR,
   output logic [31:0] ACC_BEAT_ADDR
);
   initial begin
      {MM_FAULT, BUS_FAULT, VECT_BUS_ERR, ESCALATE} = 4'h0;
      ACC_REQ_ADDR = 32'h0;
      ACC_BEAT_ADDR = 32'h0;
   end
   task automatic hit(input logic [3:0] ev, input logic [31:0] rq, input logic [31:0] bt);
      @(negedge CLK);
      {MM_FAULT, BUS_FAULT, VECT_BUS_ERR, ESCALATE} = ev;
      ACC_REQ_ADDR = rq;
      ACC_BEAT_ADDR = bt;
      @(negedge CLK);
      {MM_FAULT, BUS_FAULT, VECT_BUS_ERR, ESCALATE} = 4'h0;
      ACC_REQ_ADDR = ~rq;
      ACC_BEAT_ADDR = ~bt;
   endtask
endmodule // fcap_core

/* File: verif/test_fcap_top.sv */
// Purpose: Self-checking bench for fcap_top
// Assumes: Inputs change on falling edges
// Notes: Each scenario task judges its own results
`timescale 1ns/100ps
module test_fcap_top;
   import fcap_pkg::*;
   logic clk, arst_n, sel, wr, priv, ack, err, mmf, bf, vbe, esc, ben, hreq, breq;
   logic [11:0] addr;
   logic [31:0] wdat, rdat, rq, bt;
   int num_errors = 0;
   int n_compared = 0;
   fcap_top i_dut (.CLK(clk), .ARST_N(arst_n), .REG_SEL(sel), .REG_WR(wr), .REG_ADDR(addr),
      .REG_WDATA(wdat), .REG_PRIV(priv), .REG_RDATA(rdat), .REG_ACK(ack), .REG_ERR(err),
      .MM_FAULT(mmf), .BUS_FAULT(bf), .ACC_REQ_ADDR(rq), .ACC_BEAT_ADDR(bt),
      .VECT_BUS_ERR(vbe), .ESCALATE(esc), .BUS_FAULT_EN(ben), .HARD_FAULT_REQ(hreq),
      .BUS_FAULT_REQ(breq));
   fcap_core i_core (.CLK(clk), .MM_FAULT(mmf), .BUS_FAULT(bf), .VECT_BUS_ERR(vbe),
      .ESCALATE(esc), .ACC_REQ_ADDR(rq), .ACC_BEAT_ADDR(bt));
   initial begin
      clk = 1'h0;
      forever #12.5 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      n_compared++;
      if (got !== ex) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic acc(input logic w, input logic p, input logic [11:0] a, input logic [31:0] d,
      input logic [31:0] ex, input logic ee);
      @(negedge clk);
      {sel, wr, priv, addr, wdat} = {1'h1, w, p, a, d};
      @(negedge clk);
      chk("ack err", {30'h0, 1'h1, ee}, {30'h0, ack, err});
      chk("rdata", ex, rdat);
      sel = 1'h0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] ex);
      acc(1'h0, 1'h1, a, 32'h0, ex, 1'h0);
   endtask
   task automatic wr1(input logic [11:0] a, input logic [31:0] d);
      acc(1'h1, 1'h1, a, d, 32'h0, 1'h0);
   endtask
   task automatic t_hard(input logic [3:0] ev, input logic [31:0] m);
      i_core.hit(ev, 32'h0, 32'h0);
      chk("hard req", 32'h1, {31'h0, hreq});
      chk("bus req", 32'h0, {31'h0, breq});
      rd(OFS_HARD_STAT, m);
      wr1(OFS_HARD_STAT, m ^ 32'h4000_0002);
      rd(OFS_HARD_STAT, m);
      wr1(OFS_HARD_STAT, m);
      rd(OFS_HARD_STAT, 32'h0);
      $display("hard flag test done");
   endtask
   task automatic t_mm;
      i_core.hit(4'h8, 32'h2000_0001, 32'h2000_0004);
      rd(OFS_VALID_STAT, 32'h1);
      rd(OFS_MM_ADDR, 32'h2000_0004);
      i_core.hit(4'h8, 32'h0, 32'h3000_0000);
      rd(OFS_MM_ADDR, 32'h2000_0004);
      fork
         i_core.hit(4'h8, 32'h0, 32'h3000_0010);
         wr1(OFS_VALID_STAT, 32'h1);
      join
      rd(OFS_VALID_STAT, 32'h1);
      rd(OFS_MM_ADDR, 32'h3000_0010);
      wr1(OFS_VALID_STAT, 32'h1);
      rd(OFS_VALID_STAT, 32'h0);
      $display("memory fault test done");
   endtask
   task automatic t_bus;
      ben = 1'h1;
      i_core.hit(4'h4, 32'h4000_0003, 32'h4000_0004);
      chk("bus req", 32'h1, {31'h0, breq});
      rd(OFS_VALID_STAT, 32'h2);
      rd(OFS_BUS_ADDR, 32'h4000_0003);
      wr1(OFS_VALID_STAT, 32'h2);
      ben = 1'h0;
      i_core.hit(4'h4, 32'h0, 32'h0);
      chk("bus req off", 32'h0, {31'h0, breq});
      ben = 1'h1;
      i_core.hit(4'h6, 32'h0, 32'h0);
      chk("vect bus req", 32'h0, {31'h0, breq});
      chk("vect hard req", 32'h1, {31'h0, hreq});
      ben = 1'h0;
      wr1(OFS_HARD_STAT, 32'h2);
      $display("bus fault test done");
   endtask
   task automatic t_priv;
      logic [11:0] ofs [6] = '{12'hD28, 12'hD2C, 12'hD34, 12'hD38, 12'hD90, 12'hDEC};
      wr1(OFS_MM_ADDR, 32'hA5A5_5A5A);
      rd(OFS_MM_ADDR, 32'hA5A5_5A5A);
      foreach (ofs[i]) acc(1'h0, 1'h0, ofs[i], 32'h0, 32'h0, 1'h1);
      acc(1'h1, 1'h0, OFS_MM_ADDR, 32'h0, 32'h0, 1'h1);
      rd(OFS_MM_ADDR, 32'hA5A5_5A5A);
      rd(12'h000, 32'h0);
      $display("privilege test done");
   endtask
   task automatic t_race;
      fork
         i_core.hit(4'h3, 32'h0, 32'h0);
         wr1(OFS_HARD_STAT, 32'h4000_0002);
      join
      rd(OFS_HARD_STAT, 32'h4000_0002);
      wr1(OFS_HARD_STAT, 32'h4000_0002);
      rd(OFS_HARD_STAT, 32'h0);
      $display("set over clear test done");
   endtask
   task automatic complete_run;
      $display("compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      {sel, wr, priv, addr, wdat, ben} = '0;
      arst_n = 1'h0;
      repeat (2) @(negedge clk);
      arst_n = 1'h1;
      repeat (3) @(negedge clk);
      t_hard(4'h2, 32'h2);
      t_hard(4'h1, 32'h4000_0000);
      t_mm;
      t_bus;
      t_priv;
      t_race;
      complete_run;
   end
   initial begin
      repeat (3000) @(posedge clk);
      num_errors++;
      complete_run;
   end
endmodule // test_fcap_top
